// [src/fsp_pkg.sv]
// Purpose: shared constants and types of the flash section protection block
// Assumes: 32 KB flash, 512-byte pages, 256-byte eeprom, 32-bit apb
// Notes:   section boundaries come from two 8-bit size fuses counted in pages
package fsp_pkg;
    localparam int             ADDR_W           = 15;
    localparam int             PAGE_SHIFT       = 9;
    localparam int             PAGE_BYTES       = 512;
    localparam logic [8:0]     PAGE_ZERO        = 9'h000;
    localparam logic [14:0]    FLASH_FIRST_ADDR = 15'h0000;
    localparam logic [14:0]    FLASH_LAST_ADDR  = 15'h7fff;
    localparam logic [16:0]    FLASH_END_EXCL   = 17'h08000;
    localparam int             EE_BYTES         = 256;
    localparam logic [14:0]    EE_ADDR_MASK     = 15'h00ff;
    localparam logic [14:0]    ALL_ONES_ADDR    = 15'h7fff;
    localparam logic [2:0]     MAX_BLK_SIZE     = 3'h5;
    localparam logic [7:0]     LOADER_FUSE_DEF  = 8'h00;
    localparam logic [7:0]     CODE_FUSE_DEF    = 8'h00;
    localparam int             ERASE_CYCLES_DEF = 16;

    // apb map
    localparam logic [11:0]    CTRL_OFS         = 12'h000;
    localparam logic [11:0]    FUSE_OFS         = 12'h004;
    localparam logic [11:0]    STATUS_OFS       = 12'h008;
    localparam int             RP_BIT           = 0;
    localparam int             CWL_BIT          = 1;
    localparam int             PWL_BIT          = 2;
    localparam int             VSEL_BIT         = 3;
    localparam logic [3:0]     CTRL_RESET       = 4'h0;
    localparam int             LFUSE_LSB        = 0;
    localparam int             CFUSE_LSB        = 8;
    localparam logic [15:0]    FUSE_RESET       = 16'h0000;

    typedef enum logic [1:0] {SEC_LOADER, SEC_CODE, SEC_PARAM} fsp_sec_t;

    typedef enum logic [3:0] {
        OP_READ, OP_FETCH, OP_WRITE_B, OP_WRITE_W, OP_PAGE_ERASE,
        OP_MPAGE_ERASE, OP_EE_WRITE, OP_EE_ERASE, OP_EE_ERASE_WRITE
    } fsp_op_t;

    typedef struct packed {
        logic        valid;
        fsp_op_t     op;
        logic [14:0] addr;
        logic [2:0]  size;
    } fsp_req_t;

    typedef struct packed {
        logic done;
        logic allowed;
        logic refused;
        logic stall;
    } fsp_resp_t;

    typedef struct packed {
        logic        valid;
        fsp_op_t     op;
        logic [14:0] addr;
        logic [5:0]  count;
    } fsp_cmd_t;
endpackage

// [src/fsp_section_map.sv]
// Purpose: classify a flash byte address into loader, code or parameter section
// Assumes: fuse values count 512-byte pages
// Notes:   purely combinational
module fsp_section_map (
    input  wire logic [14:0]      addr_i,        // byte address
    input  wire logic [7:0]       loader_fuse_i, // loader size fuse
    input  wire logic [7:0]       code_fuse_i,   // code size fuse
    output fsp_pkg::fsp_sec_t     sec_o,         // section of addr_i
    output logic      [15:0]      loader_end_o   // first byte after loader; 0 when the loader fuse is zero or out of range
);
    import fsp_pkg::*;
    logic [7:0]  lf;
    logic [7:0]  cf;
    logic [16:0] lend;
    logic [16:0] cend;
    logic [16:0] a17;

    always_comb begin
        // out-of-range fuse falls back to its default
        lf = ({loader_fuse_i, PAGE_ZERO} > FLASH_END_EXCL) ? LOADER_FUSE_DEF : loader_fuse_i;
        cf = ({code_fuse_i, PAGE_ZERO} > FLASH_END_EXCL) ? CODE_FUSE_DEF : code_fuse_i;
        lend = {lf, PAGE_ZERO};
        cend = {cf, PAGE_ZERO};
        a17 = {2'b00, addr_i};
        loader_end_o = lend[15:0];
        if (lf == 8'h00) begin
            sec_o = SEC_LOADER;
        end else if (a17 < lend) begin
            sec_o = SEC_LOADER;
        end else if (cf == 8'h00) begin
            sec_o = SEC_CODE;
        end else if (cf <= lf) begin
            sec_o = SEC_PARAM;
        end else if (a17 < cend) begin
            sec_o = SEC_CODE;
        end else begin
            sec_o = SEC_PARAM;
        end
    end
endmodule

// [src/fsp_protect.sv]
// Purpose: flash section protection and self-programming gatekeeper
// Assumes: cpu request and apb master share CLOCK_I; one request per cycle
// Notes:   requests during an erase are ignored since the cpu is stalled
//
// Operation
// - Flash pages are 512 bytes; page is the smallest erasable unit.
// - Flash erases whole pages only; writes are byte or word sized.
// - Programming the section currently executing is refused.
// - Loader section can never be programmed by the cpu.
// - Code section programmable only from code running in loader.
// - Parameter section programmable only from loader or code section.
// - Section ends are fuse value times 512 bytes.
// - Loader below loader end, code up to code end, rest parameter.
// - Loader fuse zero makes the whole flash loader.
// - Code fuse zero: code section runs to flash end, no parameters.
// - Code fuse not above loader fuse: no code section, rest parameter.
// - An end beyond flash uses the default fuse value.
// - Read protect blocks loader data reads and loader execution.
// - Read protect set only from loader code; enforced once outside.
// - Write locks block programming of code or parameter section.
// - Vectors at code start after reset, loader start when selected.
// - 256-byte eeprom, erase 1..32 bytes, byte write, erase-write.
// - Cpu stalls for the whole flash erase.
//
// Decided for this implementation: the register offsets and the APB slave port.
module fsp_protect #(
    parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYCLES_DEF
) (
    input  wire logic             CLOCK_I,       // system clock 125 MHz
    input  wire logic             RST_N_I,       // async reset, active low
    input  wire logic             PSEL_I,        // apb select
    input  wire logic             PENABLE_I,     // apb enable
    input  wire logic             PWRITE_I,      // apb direction
    input  wire logic [11:0]      PADDR_I,       // apb byte address
    input  wire logic [31:0]      PWDATA_I,      // apb write data
    output logic      [31:0]      PRDATA_O,      // apb read data
    output logic                  PREADY_O,      // apb ready
    output logic                  PSLVERR_O,     // apb error
    input  wire logic [14:0]      EXEC_ADDR_I,   // address being executed
    input  fsp_pkg::fsp_req_t     REQ_I,         // cpu access request
    output fsp_pkg::fsp_resp_t    RESP_O,        // request answer
    output fsp_pkg::fsp_cmd_t     CMD_O,         // permitted memory operation
    output logic      [15:0]      VECTOR_BASE_O  // vector table byte address
);
    import fsp_pkg::*;

    typedef enum logic {ST_IDLE, ST_ERASE} fsp_state_t;

    logic [1:0]  rst_pipe;
    logic        rst_n;
    fsp_sec_t    exec_sec;
    fsp_sec_t    tgt_sec;
    logic [15:0] loader_end;

    fsp_state_t  state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    fsp_resp_t   resp_reg, resp_next;
    fsp_cmd_t    cmd_reg, cmd_next;
    logic        refused_reg, refused_next;
    logic        ok;
    logic        is_erase;

    logic [3:0]  ctrl_reg, ctrl_next;
    logic [15:0] fuse_reg, fuse_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic [15:0] vec_reg, vec_next;
    logic        acc;
    logic        wr_now;
    logic        mapped;

    // reset enters at once but leaves through two flops, so no logic sees a half-released edge
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    fsp_section_map u_exec_map (
        .addr_i        (EXEC_ADDR_I),
        .loader_fuse_i (fuse_reg[LFUSE_LSB +: 8]),
        .code_fuse_i   (fuse_reg[CFUSE_LSB +: 8]),
        .sec_o         (exec_sec),
        .loader_end_o  ()
    );

    fsp_section_map u_tgt_map (
        .addr_i        (REQ_I.addr),
        .loader_fuse_i (fuse_reg[LFUSE_LSB +: 8]),
        .code_fuse_i   (fuse_reg[CFUSE_LSB +: 8]),
        .sec_o         (tgt_sec),
        .loader_end_o  (loader_end)
    );

    function automatic logic prog_ok(input fsp_sec_t ex, input fsp_sec_t tg, input logic [3:0] c);
        case (tg)
            SEC_LOADER: prog_ok = 1'b0;
            SEC_CODE:   prog_ok = (ex == SEC_LOADER) && !c[CWL_BIT];
            SEC_PARAM:  prog_ok = (ex != SEC_PARAM) && !c[PWL_BIT];
            default:    prog_ok = 1'b0;
        endcase
    endfunction

    // clears the low address bits of a block of 2**sh bytes
    function automatic logic [14:0] blk_base(input logic [14:0] a, input logic [3:0] sh);
        blk_base = a & (ALL_ONES_ADDR << sh);
    endfunction

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        resp_next = '0;
        cmd_next = '0;
        refused_next = refused_reg;
        is_erase = (REQ_I.op == OP_PAGE_ERASE) || (REQ_I.op == OP_MPAGE_ERASE);
        case (REQ_I.op)
            OP_READ, OP_FETCH: begin
                // protection bites only once execution is outside the loader
                ok = !(tgt_sec == SEC_LOADER && ctrl_reg[RP_BIT] && exec_sec != SEC_LOADER);
            end
            OP_WRITE_B, OP_WRITE_W, OP_PAGE_ERASE: begin
                ok = prog_ok(exec_sec, tgt_sec, ctrl_reg);
            end
            OP_MPAGE_ERASE: begin
                ok = prog_ok(exec_sec, tgt_sec, ctrl_reg) && (REQ_I.size <= MAX_BLK_SIZE);
            end
            OP_EE_WRITE, OP_EE_ERASE_WRITE: begin
                ok = (exec_sec != SEC_PARAM);
            end
            OP_EE_ERASE: begin
                ok = (exec_sec != SEC_PARAM) && (REQ_I.size <= MAX_BLK_SIZE);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        case (state_reg)
            ST_IDLE: begin
                if (REQ_I.valid) begin
                    resp_next.allowed = ok;
                    resp_next.refused = !ok;
                    resp_next.done = !(ok && is_erase);
                    refused_next = !ok;
                    cmd_next.op = REQ_I.op;
                    cmd_next.valid = ok && (REQ_I.op != OP_READ) && (REQ_I.op != OP_FETCH);
                    cmd_next.count = 6'h01;
                    cmd_next.addr = REQ_I.addr;
                    case (REQ_I.op)
                        OP_WRITE_W: begin
                            cmd_next.addr = blk_base(REQ_I.addr, 4'h1);
                        end
                        OP_PAGE_ERASE: begin
                            cmd_next.addr = blk_base(REQ_I.addr, 4'(PAGE_SHIFT));
                        end
                        OP_MPAGE_ERASE: begin
                            cmd_next.addr = blk_base(REQ_I.addr, 4'(PAGE_SHIFT) + {1'b0, REQ_I.size});
                            cmd_next.count = 6'h01 << REQ_I.size;
                        end
                        OP_EE_WRITE, OP_EE_ERASE_WRITE: begin
                            cmd_next.addr = REQ_I.addr & EE_ADDR_MASK;
                        end
                        OP_EE_ERASE: begin
                            cmd_next.addr = blk_base(REQ_I.addr & EE_ADDR_MASK, {1'b0, REQ_I.size});
                            cmd_next.count = 6'h01 << REQ_I.size;
                        end
                        default: begin
                            cmd_next.addr = REQ_I.addr;
                        end
                    endcase
                    if (ok && is_erase) begin
                        resp_next.stall = 1'b1;
                        state_next = ST_ERASE;
                        cnt_next = 16'(ERASE_CYCLES - 1);
                    end
                end
            end
            ST_ERASE: begin
                if (cnt_reg == 16'h0000) begin
                    resp_next.done = 1'b1;
                    resp_next.allowed = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    resp_next.stall = 1'b1;
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            resp_reg <= '0;
            cmd_reg <= '0;
            refused_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            resp_reg <= resp_next;
            cmd_reg <= cmd_next;
            refused_reg <= refused_next;
        end
    end

    always_comb begin
        acc = PSEL_I && PENABLE_I;
        pready_next = acc && !pready_reg;
        wr_now = acc && pready_reg && PWRITE_I;
        mapped = (PADDR_I == CTRL_OFS) || (PADDR_I == FUSE_OFS) || (PADDR_I == STATUS_OFS);
        pslverr_next = pready_next && !mapped;
        prdata_next = 32'h0000_0000;
        ctrl_next = ctrl_reg;
        fuse_next = fuse_reg;
        if (pready_next && !PWRITE_I) begin
            case (PADDR_I)
                CTRL_OFS:   prdata_next = {28'h0000000, ctrl_reg};
                FUSE_OFS:   prdata_next = {16'h0000, fuse_reg};
                STATUS_OFS: prdata_next = {loader_end, 12'h000, refused_reg, state_reg == ST_ERASE, exec_sec};
                default:    prdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_now && PADDR_I == CTRL_OFS) begin
            // protect and locks are sticky: a later write of zero cannot reopen them
            ctrl_next[RP_BIT] = ctrl_reg[RP_BIT] || (PWDATA_I[RP_BIT] && exec_sec == SEC_LOADER);
            ctrl_next[CWL_BIT] = ctrl_reg[CWL_BIT] || PWDATA_I[CWL_BIT];
            ctrl_next[PWL_BIT] = ctrl_reg[PWL_BIT] || PWDATA_I[PWL_BIT];
            ctrl_next[VSEL_BIT] = PWDATA_I[VSEL_BIT];
        end
        if (wr_now && PADDR_I == FUSE_OFS) begin
            fuse_next = PWDATA_I[15:0];
        end
        vec_next = ctrl_reg[VSEL_BIT] ? {1'b0, FLASH_FIRST_ADDR} : loader_end;
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            fuse_reg <= FUSE_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            vec_reg <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            fuse_reg <= fuse_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            vec_reg <= vec_next;
        end
    end

    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign RESP_O = resp_reg;
    assign CMD_O = cmd_reg;
    assign VECTOR_BASE_O = vec_reg;

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!rst_n);

    logic idle_req;
    logic is_prog;
    assign idle_req = REQ_I.valid && state_reg == ST_IDLE;
    assign is_prog = REQ_I.op inside {OP_WRITE_B, OP_WRITE_W, OP_PAGE_ERASE, OP_MPAGE_ERASE};

    sequence s_erase_go;
        idle_req && is_erase && ok;
    endsequence

    sequence s_erase_hold;
        RESP_O.stall && !RESP_O.done;
    endsequence

    a_loader_no_prog: assert property (
        idle_req && is_prog && tgt_sec == SEC_LOADER |=> RESP_O.refused && !CMD_O.valid)
        else $error("loader section was programmed");
    a_same_sec_prog: assert property (
        idle_req && is_prog && tgt_sec == exec_sec |=> RESP_O.refused && !CMD_O.valid)
        else $error("own section was programmed");
    a_code_from_loader: assert property (
        CMD_O.valid && $past(tgt_sec) == SEC_CODE && $past(is_prog) |-> $past(exec_sec) == SEC_LOADER)
        else $error("code section programmed from outside loader");
    a_param_from_exec: assert property (
        idle_req && is_prog && tgt_sec == SEC_PARAM && exec_sec == SEC_PARAM |=> RESP_O.refused)
        else $error("parameter section programmed from itself");
    a_read_protect: assert property (
        idle_req && REQ_I.op inside {OP_READ, OP_FETCH} && tgt_sec == SEC_LOADER
        && ctrl_reg[RP_BIT] && exec_sec != SEC_LOADER |=> RESP_O.refused && RESP_O.done)
        else $error("protected loader read allowed");
    a_write_lock: assert property (
        idle_req && is_prog && tgt_sec == SEC_CODE && ctrl_reg[CWL_BIT] |=> !CMD_O.valid)
        else $error("locked code section programmed");
    a_erase_stall: assert property (
        s_erase_go |=> s_erase_hold [*2])
        else $error("erase did not stall the cpu");
    a_refuse_clean: assert property (
        RESP_O.refused |-> RESP_O.done && !RESP_O.stall && !CMD_O.valid && !RESP_O.allowed)
        else $error("refused request disturbed memory");
    a_page_align: assert property (
        CMD_O.valid && CMD_O.op == OP_PAGE_ERASE |-> CMD_O.addr[8:0] == 9'h000)
        else $error("page erase not page aligned");
    a_vector_base: assert property (
        ctrl_reg[VSEL_BIT] |=> VECTOR_BASE_O == 16'h0000)
        else $error("vector table not at loader start");
endmodule

// [test/fsp_cpu_model.sv]
// Purpose: behavioural cpu core issuing fetch, read and programming requests
// Assumes: answers are registered and each request is a one-cycle pulse
// Notes:   the executing address stays put until the next request or point
module fsp_cpu_model (
    input  wire logic          clk_i,  // system clock
    input  fsp_pkg::fsp_resp_t resp_i, // answer from the block
    input  fsp_pkg::fsp_cmd_t  cmd_i,  // permitted memory operation
    output fsp_pkg::fsp_req_t  req_o,  // access request
    output logic [14:0]        exec_o  // address being executed
);
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;

    initial begin
        req_o  = '0;
        exec_o = '0;
    end

    task automatic point(input logic [14:0] ex);
        @(posedge clk_i);
        exec_o <= ex;
    endtask

    // gap makes the core slow between requests; released address is inverted so it cannot be reused
    task automatic access(input int gap, input fsp_op_t op, input logic [14:0] ex, input logic [14:0] a,
                          input logic [2:0] sz, output logic ok, output int stalls, output fsp_cmd_t cmd);
        ok     = 1'b0;
        stalls = 0;
        cmd    = '0;
        repeat (gap + 1) @(posedge clk_i);
        exec_o <= ex;
        req_o  <= '{1'b1, op, a, sz};
        @(posedge clk_i);
        req_o  <= '{1'b0, op, ~a, sz};
        // no cycle limit here: a missing answer is caught by the bench timeout
        do begin
            @(posedge clk_i);
            stalls += int'(resp_i.stall);
            if (cmd_i.valid === 1'b1) begin
                cmd = cmd_i;
            end
        end while (resp_i.done !== 1'b1);
        ok = (resp_i.done === 1'b1) && (resp_i.allowed === 1'b1) && (resp_i.refused === 1'b0);
    endtask
endmodule

// [test/test_fsp_protect.sv]
// Purpose: self-checking bench of the flash section protection block
// Assumes: erase shortened to three cycles so the run stays short
// Notes:   addresses and pacing come from an lfsr with a fixed start
module test_fsp_protect import fsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          EC = 3;
    localparam logic [15:0] FT [8] = '{16'h0804, 16'h0004, 16'h0408, 16'h0404,
                                       16'h0841, 16'h4110, 16'h0500, 16'h0840};
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, ok, err, lref;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [14:0] exec, ex, tg;
    logic [15:0] vbase;
    logic [7:0]  lf, cf;
    int          fail_count, checked, cycles, st;
    fsp_sec_t    es, ts;
    fsp_req_t    req;
    fsp_resp_t   resp;
    fsp_cmd_t    cmd, got;

    fsp_protect #(.ERASE_CYCLES(EC)) i_fsp_protect (
        .CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .EXEC_ADDR_I(exec), .REQ_I(req), .RESP_O(resp), .CMD_O(cmd), .VECTOR_BASE_O(vbase));

    fsp_cpu_model i_fsp_cpu_model (.clk_i(clk), .resp_i(resp), .cmd_i(cmd), .req_o(req), .exec_o(exec));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // fuse ends past the flash fall back to the default fuse value
    function automatic fsp_sec_t sec_of(input logic [14:0] a, input logic [7:0] l, input logic [7:0] c);
        if ({l, 9'h000} > FLASH_END_EXCL) l = LOADER_FUSE_DEF;
        if ({c, 9'h000} > FLASH_END_EXCL) c = CODE_FUSE_DEF;
        if (l == 8'h00 || {2'b00, a} < {l, 9'h000}) return SEC_LOADER;
        if (c == 8'h00 || (c > l && {2'b00, a} < {c, 9'h000})) return SEC_CODE;
        return SEC_PARAM;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic try(input fsp_op_t op, input logic [14:0] x, input logic [14:0] a, input logic [2:0] sz,
                       input logic eok, input logic [14:0] ea);
        logic       er;
        logic [5:0] ecnt;
        er = eok && (op == OP_PAGE_ERASE || op == OP_MPAGE_ERASE);
        ecnt = !eok ? 6'h00 : (op == OP_MPAGE_ERASE || op == OP_EE_ERASE) ? 6'(1 << sz) : 6'h01;
        i_fsp_cpu_model.access(int'(lfsr() % 3), op, x, a, sz, ok, st, got);
        chk({31'h0, ok}, {31'h0, eok});
        chk(32'(st), er ? 32'(EC) : 32'h0);
        if (op != OP_READ && op != OP_FETCH) chk({6'h0, got.op, got.count, got.valid, got.addr},
                                                 {6'h0, 4'(eok ? op : OP_READ), ecnt, eok, eok ? ea : 15'h0000});
        lref = !eok;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h289e;
        fail_count = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, CTRL_OFS, '0);
        chk(rd, {28'h0, CTRL_RESET});
        apb(1'b0, FUSE_OFS, '0);
        chk(rd, {16'h0, FUSE_RESET});
        apb(1'b1, 12'h00c, 32'h0000ffff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h00c, '0);
        chk({err, rd[30:0]}, 32'h80000000);
        try(OP_WRITE_B, 15'h0000, 15'h4321, 3'h0, 1'b0, '0);
        $display("reset test done");
        for (int k = 0; k < 8; k++) begin
            lf = FT[k][7:0];
            cf = FT[k][15:8];
            apb(1'b1, FUSE_OFS, {16'h0, FT[k]});
            for (int i = 0; i < 8; i++) begin
                ex = (i < 2) ? 15'({lf, 9'h000} - 17'(i)) : (i < 4) ? 15'({cf, 9'h000} - 17'(i - 2)) : 15'(lfsr());
                tg = 15'(lfsr());
                es = sec_of(ex, lf, cf);
                ts = sec_of(tg, lf, cf);
                i_fsp_cpu_model.point(ex);
                apb(1'b0, STATUS_OFS, '0);
                chk({28'h0, rd[3:0]}, {28'h0, lref, 1'b0, 2'(es)});
                if (lf != 8'h00 && {lf, 9'h000} <= FLASH_END_EXCL) chk({16'h0, rd[31:16]}, {15'h0, lf, 9'h000});
                try(OP_WRITE_B, ex, tg, 3'h0, ts != SEC_LOADER && es < ts, tg);
            end
        end
        $display("section test done");
        apb(1'b1, FUSE_OFS, 32'h00000804);
        try(OP_PAGE_ERASE, 15'h0000, 15'h0a33, 3'h0, 1'b1, 15'h0a00);
        try(OP_MPAGE_ERASE, 15'h0000, 15'h1a00, 3'h2, 1'b1, 15'h1800);
        try(OP_WRITE_W, 15'h0900, 15'h2103, 3'h0, 1'b1, 15'h2102);
        try(OP_PAGE_ERASE, 15'h2000, 15'h2200, 3'h0, 1'b0, '0);
        chk({16'h0, vbase}, 32'h0800);
        for (int s = 0; s < 6; s++) begin
            try(OP_EE_ERASE, 15'h0000, 15'h00ff, 3'(s), 1'b1, 15'h00ff & ~15'((1 << s) - 1));
        end
        try(OP_EE_ERASE, 15'h0900, 15'h0037, 3'h6, 1'b0, '0);
        try(OP_EE_WRITE, 15'h0900, 15'h00c5, 3'h0, 1'b1, 15'h00c5);
        try(OP_EE_ERASE_WRITE, 15'h2000, 15'h0011, 3'h0, 1'b0, '0);
        try(OP_EE_ERASE_WRITE, 15'h0000, 15'h0011, 3'h0, 1'b1, 15'h0011);
        $display("erase test done");
        apb(1'b1, CTRL_OFS, 32'h2);
        try(OP_WRITE_B, 15'h0000, 15'h0900, 3'h0, 1'b0, '0);
        try(OP_WRITE_B, 15'h0900, 15'h2000, 3'h0, 1'b1, 15'h2000);
        apb(1'b1, CTRL_OFS, 32'h6);
        try(OP_PAGE_ERASE, 15'h0900, 15'h2000, 3'h0, 1'b0, '0);
        i_fsp_cpu_model.point(15'h0900);
        apb(1'b1, CTRL_OFS, 32'h7);
        apb(1'b0, CTRL_OFS, '0);
        chk(rd, 32'h6);
        i_fsp_cpu_model.point(15'h0000);
        apb(1'b1, CTRL_OFS, 32'h7);
        apb(1'b0, CTRL_OFS, '0);
        chk(rd, 32'h7);
        try(OP_READ, 15'h0000, 15'h0010, 3'h0, 1'b1, '0);
        try(OP_FETCH, 15'h0900, 15'h0010, 3'h0, 1'b0, '0);
        try(OP_READ, 15'h0900, 15'h0010, 3'h0, 1'b0, '0);
        try(OP_READ, 15'h0900, 15'h2000, 3'h0, 1'b1, '0);
        i_fsp_cpu_model.point(15'h0000);
        apb(1'b1, CTRL_OFS, 32'hf);
        apb(1'b0, CTRL_OFS, '0);
        chk(rd, 32'hf);
        chk({16'h0, vbase}, 32'h0);
        $display("protect test done");
        stop_test();
    end
endmodule
